//--- rtl/flash_erase_key_data_ctrl.v
// Flash erase sequencer, unlock key, program data and address mapping
`timescale 1ns/100ps
`default_nettype none
`include "flash_ctrl_regs.vh"
module flash_erase_key_data_ctrl #(
  parameter [31:0] MASS_CYCLES = `MASS_CYCLES,
  parameter [31:0] PAGE_CYCLES = `PAGE_CYCLES,
  parameter [31:0] PROG_CYCLES = `PROG_CYCLES
) (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        io_wr_in,
  input  wire        io_rd_in,
  input  wire        mem_rd_in,
  input  wire        mem_wr_in,
  input  wire [7:0]  io_addr_in,
  input  wire [23:0] mem_addr_in,
  input  wire [7:0]  wdata_in,
  input  wire        flash_enable_in,
  input  wire        sram_hit_in,
  input  wire        ext_cs_hit_in,
  output reg  [7:0]  rdata_out,
  output reg         wait_out,
  output reg         flash_sel_out,
  output reg         ext_cs_out,
  output reg         done_out,
  output reg         error_out,
  output reg         arr_erase_out,
  output reg         arr_mass_out,
  output reg         arr_prog_out,
  output reg  [7:0]  arr_page_out,
  output reg  [2:0]  arr_row_out,
  output reg  [6:0]  arr_col_out,
  output reg  [7:0]  arr_data_out
);
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_ERASE = 2'h1;
  localparam [1:0] ST_PROG  = 2'h2;

  reg  [1:0]  state_q;
  reg  [31:0] timer_q;
  reg  [1:0]  key_q;
  reg         unlocked_q;
  reg  [7:0]  data_q;
  reg  [7:0]  base_q;
  reg  [7:0]  divider_q;
  reg  [7:0]  guard_q;
  reg  [7:0]  page_q;
  reg  [2:0]  row_q;
  reg  [6:0]  col_q;
  reg         row_burst_enable_q;
  reg         done_q;
  reg         err_q;

  wire io_w  = io_wr_in;
  wire busy  = (state_q != ST_IDLE);
  wire wr_key  = io_w && (io_addr_in == `OFS_UNLOCK_KEY);
  wire wr_data = io_w && (io_addr_in == `OFS_PROGRAM_BYTE);
  wire wr_ctl  = io_w && (io_addr_in == `OFS_PROG_CTRL);
  wire wr_st   = io_w && (io_addr_in == `OFS_STATUS);
  wire wr_div  = io_w && (io_addr_in == `OFS_DIVIDER);
  wire wr_grd  = io_w && (io_addr_in == `OFS_GUARD);
  wire info_pg = page_q[`INFO_PAGE_BIT];
  wire page_guarded = !info_pg && guard_q[page_q[6:4]];
  // [RL16] 128KB window on the top seven address bits
  wire hit = flash_enable_in && (mem_addr_in[23:17] == base_q[7:1]);
  wire mem_acc = mem_rd_in || mem_wr_in;
  wire start_mass = wr_ctl && wdata_in[`PC_MASS_BIT] && !busy;
  wire start_page = wr_ctl && wdata_in[`PC_PAGE_BIT] && !busy;
  wire start_prog = wr_data && (state_q == ST_IDLE);
  wire fin = busy && (timer_q == 32'h0000_0001);

  always @(posedge clk_in) begin
    if (rst_in) begin
      state_q            <= ST_IDLE;
      timer_q            <= 32'h0000_0000;
      key_q              <= 2'h0;
      unlocked_q         <= 1'b0;
      data_q             <= `RST_ZERO;
      base_q             <= `RST_BASE;
      divider_q          <= `RST_DIVIDER;
      guard_q            <= `RST_GUARD;
      page_q             <= `RST_ZERO;
      row_q              <= 3'h0;
      col_q              <= 7'h00;
      row_burst_enable_q <= 1'b0;
      done_q             <= 1'b0;
      err_q              <= 1'b0;
      arr_erase_out      <= 1'b0;
      arr_mass_out       <= 1'b0;
      arr_prog_out       <= 1'b0;
      arr_data_out       <= `ERASED_BYTE;
    end else begin
      arr_erase_out <= 1'b0;
      arr_prog_out  <= 1'b0;
      // [RL8] I/O writes only
      if (io_w) begin
        // [RL7] Two-step key
        if (wr_key && wdata_in == `KEY_FIRST)
          key_q <= 2'h1;
        else if (wr_key && wdata_in == `KEY_SECOND && key_q == 2'h1)
          key_q <= 2'h2;
        else
          key_q <= 2'h0;
        if (wr_key && wdata_in == `KEY_SECOND && key_q == 2'h1)
          unlocked_q <= 1'b1;
      end
      // [RL9] Relock on either write
      if (wr_div || wr_grd)
        unlocked_q <= 1'b0;
      if (wr_div && unlocked_q)
        divider_q <= wdata_in;
      // Locked guard writes set every block guard bit
      if (wr_grd)
        guard_q <= unlocked_q ? wdata_in : `RST_GUARD;
      // [RL15] Bit 0 held at zero
      if (io_w && io_addr_in == `OFS_ARRAY_BASE)
        base_q <= {wdata_in[7:1], 1'b0};
      if (io_w && io_addr_in == `OFS_PAGE_SEL)
        page_q <= wdata_in;
      if (io_w && io_addr_in == `OFS_ROW_SEL)
        row_q <= wdata_in[2:0];
      if (io_w && io_addr_in == `OFS_COL_SEL)
        col_q <= wdata_in[6:0];
      if (wr_ctl)
        row_burst_enable_q <= wdata_in[`PC_ROW_BIT];
      // [RL14] Holds last written value
      if (wr_data)
        data_q <= wdata_in;
      // Status clears by writing one; hardware set wins below
      if (wr_st) begin
        if (wdata_in[`ST_DONE_BIT])
          done_q <= 1'b0;
        if (wdata_in[`ST_ERR_BIT])
          err_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          if (start_mass) begin
            // [RL20] Refuse mass erase if guarded
            if (guard_q != `RST_ZERO) begin
              err_q <= 1'b1;
            end else begin
              // [RL5] Whole array, self timed
              state_q       <= ST_ERASE;
              timer_q       <= MASS_CYCLES;
              arr_mass_out  <= 1'b1;
              arr_erase_out <= 1'b1;
              arr_page_out  <= page_q;
              arr_data_out  <= `ERASED_BYTE;
            end
          end else if (start_page) begin
            // [RL21] Guarded page skipped
            if (page_guarded) begin
              err_q <= 1'b1;
            end else begin
              // [RL6] Selected page, self timed
              state_q       <= ST_ERASE;
              timer_q       <= PAGE_CYCLES;
              arr_mass_out  <= 1'b0;
              arr_erase_out <= 1'b1;
              arr_page_out  <= page_q;
              // [RL1] Erased bytes read FFh
              arr_data_out  <= `ERASED_BYTE;
            end
          end else if (start_prog) begin
            if (page_guarded) begin
              err_q <= 1'b1;
            end else begin
              // [RL11] Byte to page, row, column
              state_q      <= ST_PROG;
              timer_q      <= PROG_CYCLES;
              arr_prog_out <= 1'b1;
              arr_page_out <= page_q;
              arr_row_out  <= row_q;
              arr_col_out  <= col_q;
              arr_data_out <= wdata_in;
            end
          end
        end
        ST_ERASE: begin
          // [RL2] Counts down without the CPU
          timer_q <= timer_q - 32'h0000_0001;
          if (fin) begin
            state_q <= ST_IDLE;
            // [RL3] Completion status
            done_q  <= 1'b1;
          end
        end
        ST_PROG: begin
          timer_q <= timer_q - 32'h0000_0001;
          if (fin) begin
            state_q <= ST_IDLE;
            // [RL12] Auto-increment, one row max
            if (row_burst_enable_q) begin
              if (col_q == `COL_LAST) begin
                row_burst_enable_q <= 1'b0;
                // [RL19] Row program finished
                done_q <= 1'b1;
              end
              col_q <= col_q + 7'h01;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Registered outputs
  always @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out     <= `RST_ZERO;
      wait_out      <= 1'b0;
      flash_sel_out <= 1'b0;
      ext_cs_out    <= 1'b0;
      done_out      <= 1'b0;
      error_out     <= 1'b0;
    end else begin
      // [RL4] Stall flash access while busy; a byte program stalls the
      // CPU until the byte is in, so back-to-back data writes are safe
      wait_out      <= (busy && hit && !sram_hit_in && mem_acc) ||
                       (busy && wr_data) || start_prog ||
                       ((state_q == ST_PROG) && !fin);
      // [RL18] SRAM wins
      flash_sel_out <= hit && !sram_hit_in && mem_acc;
      // [RL17] Flash masks external select
      ext_cs_out    <= ext_cs_hit_in && !hit && !sram_hit_in && mem_acc;
      // [RL19] Completion and error sources
      done_out      <= done_q;
      error_out     <= err_q;
      if (io_rd_in) begin
        case (io_addr_in)
          `OFS_PROGRAM_BYTE: rdata_out <= data_q;
          `OFS_ARRAY_BASE:   rdata_out <= base_q;
          `OFS_DIVIDER:      rdata_out <= divider_q;
          `OFS_GUARD:        rdata_out <= guard_q;
          `OFS_STATUS:       rdata_out <= {5'h00, busy, err_q, done_q};
          `OFS_PROG_CTRL:    rdata_out <= {5'h00, row_burst_enable_q, 2'h0};
          `OFS_PAGE_SEL:     rdata_out <= page_q;
          `OFS_ROW_SEL:      rdata_out <= {5'h00, row_q};
          `OFS_COL_SEL:      rdata_out <= {1'b0, col_q};
          // [RL10] Key register reads as zero
          default:           rdata_out <= `RST_ZERO;
        endcase
      end
    end
  end
endmodule // flash_erase_key_data_ctrl
`default_nettype wire

//--- rtl/flash_ctrl_regs.vh
// Register map, field positions and timing constants for the flash controller
// Contract
// [RL1] Erase leaves every erased byte at FFh.
// [RL2] Mass and page erase are self-timed without CPU help.
// [RL3] Erase completion sets a done status bit.
// [RL4] CPU flash access during erase is held in wait until done.
// [RL5] Mass erase clears whole array plus info page, about 200 ms.
// [RL6] Page erase clears the selected main or info page, about 10 ms.
// [RL7] Consecutive I/O writes B6h then 49h unlock divider and guard.
// [RL8] Only I/O writes advance or break the key sequence.
// [RL9] Writing divider or guard register relocks both.
// [RL10] Unlock key register is write only; reads undefined.
// [RL11] Single-byte mode: data write programs byte at page, row, column.
// [RL12] Row mode: column increments per byte; at most 128 bytes per row.
// [RL13] Software sets row burst enable before a multibyte sequence.
// [RL14] Data register read returns last value written, not flash.
// [RL15] Base upper bits [7:1] top of address; bit 0 reads zero.
// [RL16] Mapping register places flash anywhere in 16MB space.
// [RL17] Flash covering an address suppresses the external chip select.
// [RL18] SRAM wins over flash where windows overlap.
// [RL19] Completion source on erase or row program; separate error source.
// [RL20] Mass erase refused while any block guard bit is set.
// [RL21] Page erase in a guarded block is skipped and flags error.
`ifndef FLASH_CTRL_REGS_VH
`define FLASH_CTRL_REGS_VH
`define OFS_UNLOCK_KEY    8'hF5
`define OFS_PROGRAM_BYTE  8'hF6
`define OFS_ARRAY_BASE    8'hF7
`define OFS_DIVIDER       8'hF9
`define OFS_GUARD         8'hFA
`define OFS_STATUS        8'hFB
`define OFS_PROG_CTRL     8'hFC
`define OFS_PAGE_SEL      8'hFD
`define OFS_ROW_SEL       8'hFE
`define OFS_COL_SEL       8'hFF
`define KEY_FIRST         8'hB6
`define KEY_SECOND        8'h49
`define ERASED_BYTE       8'hFF
`define RST_BASE          8'h00
`define RST_DIVIDER       8'h01
`define RST_GUARD         8'hFF
`define RST_ZERO          8'h00
// Program control bits
`define PC_MASS_BIT       0
`define PC_PAGE_BIT       1
`define PC_ROW_BIT        2
// Status bits
`define ST_DONE_BIT       0
`define ST_ERR_BIT        1
`define ST_BUSY_BIT       2
`define INFO_PAGE_BIT     7
`define COL_LAST          7'h7F
`define CLK_MHZ           200
`define MASS_ERASE_MS     200
`define PAGE_ERASE_MS     10
`define PROG_BYTE_NS      85000
`define CLK_NS            5
// Kept in this order so the 32-bit product never overflows
`define MASS_CYCLES       (`MASS_ERASE_MS * `CLK_MHZ * 1000)
`define PAGE_CYCLES       (`PAGE_ERASE_MS * `CLK_MHZ * 1000)
`define PROG_CYCLES       ((`PROG_BYTE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

//--- tb/flash_array_model.sv
// Behavioural flash array behind the sequencer's array port
`timescale 1ns/100ps
`default_nettype none
module flash_array_model (
  input wire logic       clk_in,
  input wire logic       erase_in,
  input wire logic       prog_in,
  input wire logic [6:0] col_in,
  input wire logic [7:0] data_in
);
  // One row is enough to observe erase and column stepping
  logic [7:0] mem [0:127];
  always @(posedge clk_in) begin
    if (erase_in) begin
      for (int i = 0; i < 128; i++)
        mem[i] <= 8'hFF;
    end
    if (prog_in) mem[col_in] <= data_in;
  end
endmodule // flash_array_model
`default_nettype wire

//--- tb/flash_seq_chk.sv
// Port assertions for the flash sequencer
`timescale 1ns/100ps
`default_nettype none
`include "flash_ctrl_regs.vh"
module flash_seq_chk #(
  parameter [31:0] MASS_CYCLES = 20
) (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       io_wr_in,
  input wire logic       io_rd_in,
  input wire logic       mem_rd_in,
  input wire logic       sram_hit_in,
  input wire logic [7:0] io_addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] rdata_out,
  input wire logic       wait_out,
  input wire logic       flash_sel_out,
  input wire logic       ext_cs_out,
  input wire logic       done_out,
  input wire logic       arr_erase_out,
  input wire logic       arr_prog_out,
  input wire logic [7:0] arr_data_out
);
  localparam int EMAX = MASS_CYCLES + 8;
  logic [7:0] data_q;
  logic       data_v_q;
  logic       ers_q;
  wire        wr_f6 = io_wr_in && io_addr_in == `OFS_PROGRAM_BYTE;
  wire        rd_f6 = io_rd_in && io_addr_in == `OFS_PROGRAM_BYTE;
  // Erase tracking only clears on a fresh done, so stale done stays vacuous
  always @(posedge clk_in) begin
    if (rst_in) begin
      data_v_q <= 1'h0;
      ers_q    <= 1'h0;
    end else begin
      if (wr_f6) data_q <= wdata_in;
      if (wr_f6) data_v_q <= 1'h1;
      if (arr_erase_out) ers_q <= 1'h1;
      else if ($rose(done_out)) ers_q <= 1'h0;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_prog_req;
    wr_f6 && !wait_out && !ers_q;
  endsequence
  sequence s_prog_ack;
    wait_out && arr_prog_out;
  endsequence
  a_prog_starts: assert property (s_prog_req |=> s_prog_ack)
    else $error("program did not start");
  a_prog_data: assert property (arr_prog_out && data_v_q |->
    arr_data_out == data_q) else $error("wrong byte sent to array");
  a_key_reads_zero: assert property (io_rd_in &&
    io_addr_in == `OFS_UNLOCK_KEY |=> rdata_out == 8'h00)
    else $error("key register read not zero");
  a_base_bit0: assert property (io_rd_in &&
    io_addr_in == `OFS_ARRAY_BASE |=> !rdata_out[0])
    else $error("base reserved bit not zero");
  a_data_readback: assert property (rd_f6 && data_v_q |=>
    rdata_out == $past(data_q)) else $error("data readback wrong");
  a_sram_wins: assert property (mem_rd_in && sram_hit_in |=>
    !flash_sel_out) else $error("flash answered over sram");
  a_cs_yields: assert property (flash_sel_out |-> !ext_cs_out)
    else $error("chip select with flash");
  a_erase_done: assert property (arr_erase_out |->
    ##[1:EMAX] done_out) else $error("erase never finished");
  a_erase_stall: assert property (ers_q && !done_out &&
    flash_sel_out |-> wait_out) else $error("no stall in erase");
endmodule // flash_seq_chk
bind flash_erase_key_data_ctrl flash_seq_chk #(.MASS_CYCLES(MASS_CYCLES))
  i_chk (.clk_in(clk_in), .rst_in(rst_in), .io_wr_in(io_wr_in),
  .io_rd_in(io_rd_in), .mem_rd_in(mem_rd_in), .sram_hit_in(sram_hit_in),
  .io_addr_in(io_addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
  .wait_out(wait_out), .flash_sel_out(flash_sel_out),
  .ext_cs_out(ext_cs_out), .done_out(done_out),
  .arr_erase_out(arr_erase_out), .arr_prog_out(arr_prog_out),
  .arr_data_out(arr_data_out));
`default_nettype wire

//--- tb/tb.sv
// Register level bench for the flash sequencer
`timescale 1ns/100ps
`default_nettype none
`include "flash_ctrl_regs.vh"
module tb;
  logic        clk_in = 1'h0, rst_in = 1'h1, io_wr_in = 1'h0;
  logic        io_rd_in = 1'h0, mem_rd_in = 1'h0, sram_hit_in = 1'h0;
  logic        ext_cs_hit_in = 1'h0, wait_out, flash_sel_out, ext_cs_out;
  logic        done_out, error_out, arr_erase_out, arr_mass_out;
  logic        arr_prog_out, flash_enable_in = 1'h1;
  logic [7:0]  io_addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
  logic [7:0]  arr_page_out, arr_data_out;
  logic [23:0] mem_addr_in = 24'h000000;
  logic [2:0]  arr_row_out;
  logic [6:0]  arr_col_out;
  int          checks = 0, miscompares = 0, n;
  flash_erase_key_data_ctrl #(.MASS_CYCLES(20), .PAGE_CYCLES(10),
    .PROG_CYCLES(5)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .mem_rd_in(mem_rd_in),
    .mem_wr_in(1'h0), .io_addr_in(io_addr_in), .mem_addr_in(mem_addr_in),
    .wdata_in(wdata_in), .flash_enable_in(flash_enable_in),
    .sram_hit_in(sram_hit_in),
    .ext_cs_hit_in(ext_cs_hit_in), .rdata_out(rdata_out),
    .wait_out(wait_out), .flash_sel_out(flash_sel_out),
    .ext_cs_out(ext_cs_out), .done_out(done_out), .error_out(error_out),
    .arr_erase_out(arr_erase_out), .arr_mass_out(arr_mass_out),
    .arr_prog_out(arr_prog_out), .arr_page_out(arr_page_out),
    .arr_row_out(arr_row_out), .arr_col_out(arr_col_out),
    .arr_data_out(arr_data_out));
  flash_array_model i_arr (.clk_in(clk_in), .erase_in(arr_erase_out),
    .prog_in(arr_prog_out), .col_in(arr_col_out), .data_in(arr_data_out));
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  task end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    io_wr_in = 1'h1;
    io_addr_in = a;
    wdata_in = d;
    @(negedge clk_in);
    io_wr_in = 1'h0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_in);
    io_rd_in = 1'h1;
    io_addr_in = a;
    @(negedge clk_in);
    io_rd_in = 1'h0;
    @(negedge clk_in);
    chk(rdata_out, e);
  endtask
  // Bounded wait for done, or for the stall to drop
  task hold(input logic d);
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while ((d ? done_out : !wait_out) !== 1'h1 && n < 200);
    if (n >= 200) miscompares++;
  endtask
  task probe(input logic [23:0] a, input logic s, c, input logic [7:0] e);
    @(negedge clk_in);
    mem_rd_in = 1'h1;
    mem_addr_in = a;
    sram_hit_in = s;
    ext_cs_hit_in = c;
    @(negedge clk_in);
    chk({6'h00, flash_sel_out, ext_cs_out}, e);
    mem_rd_in = 1'h0;
  endtask
  task unlock();
    wr(`OFS_UNLOCK_KEY, `KEY_FIRST);
    wr(`OFS_UNLOCK_KEY, `KEY_SECOND);
  endtask
  initial begin
    repeat (20) @(negedge clk_in);
    rst_in = 1'h0;
    rd(`OFS_ARRAY_BASE, 8'h00);
    rd(`OFS_GUARD, 8'hFF);
    wr(`OFS_DIVIDER, 8'h22);
    rd(`OFS_DIVIDER, 8'h01);
    wr(`OFS_UNLOCK_KEY, `KEY_FIRST);
    rd(`OFS_UNLOCK_KEY, 8'h00);
    probe(24'h400000, 1'h0, 1'h1, 8'h01);
    wr(`OFS_UNLOCK_KEY, `KEY_SECOND);
    wr(`OFS_GUARD, 8'h00);
    rd(`OFS_GUARD, 8'h00);
    wr(`OFS_DIVIDER, 8'h22);
    rd(`OFS_DIVIDER, 8'h01);
    wr(`OFS_UNLOCK_KEY, `KEY_FIRST);
    wr(`OFS_PAGE_SEL, 8'h01);
    wr(`OFS_UNLOCK_KEY, `KEY_SECOND);
    wr(`OFS_DIVIDER, 8'h22);
    rd(`OFS_DIVIDER, 8'h01);
    wr(`OFS_COL_SEL, 8'h10);
    wr(`OFS_PROGRAM_BYTE, 8'h5A);
    hold(1'h0);
    chk(i_arr.mem[16], 8'h5A);
    rd(`OFS_PROGRAM_BYTE, 8'h5A);
    wr(`OFS_PROG_CTRL, 8'h01);
    probe(24'h000100, 1'h0, 1'h1, 8'h02);
    mem_rd_in = 1'h1;
    @(negedge clk_in);
    chk({7'h00, wait_out}, 8'h01);
    hold(1'h1);
    chk({7'h00, n > 12}, 8'h01);
    repeat (2) @(negedge clk_in);
    chk({7'h00, wait_out}, 8'h00);
    mem_rd_in = 1'h0;
    chk(i_arr.mem[16], `ERASED_BYTE);
    rd(`OFS_STATUS, 8'h01);
    wr(`OFS_STATUS, 8'h03);
    unlock();
    wr(`OFS_GUARD, 8'h80);
    wr(`OFS_PROG_CTRL, 8'h01);
    rd(`OFS_STATUS, 8'h02);
    wr(`OFS_ARRAY_BASE, 8'hA5);
    rd(`OFS_ARRAY_BASE, 8'hA4);
    probe(24'hA50010, 1'h0, 1'h1, 8'h02);
    probe(24'hA60000, 1'h0, 1'h1, 8'h01);
    probe(24'hA40000, 1'h1, 1'h0, 8'h00);
    flash_enable_in = 1'h0;
    probe(24'hA50010, 1'h0, 1'h1, 8'h01);
    flash_enable_in = 1'h1;
    wr(`OFS_STATUS, 8'h03);
    wr(`OFS_COL_SEL, 8'h7E);
    // Row burst enabled before the multibyte sequence
    wr(`OFS_PROG_CTRL, 8'h04);
    wr(`OFS_PROGRAM_BYTE, 8'h11);
    hold(1'h0);
    wr(`OFS_PROGRAM_BYTE, 8'h22);
    hold(1'h0);
    chk(i_arr.mem[126], 8'h11);
    chk(i_arr.mem[127], 8'h22);
    @(negedge clk_in);
    chk({7'h00, done_out}, 8'h01);
    wr(`OFS_STATUS, 8'h03);
    wr(`OFS_PROG_CTRL, 8'h02);
    hold(1'h1);
    chk({7'h00, n < 12}, 8'h01);
    chk(i_arr.mem[126], `ERASED_BYTE);
    end_of_test();
  end
  // Whole run is well under a thousand cycles
  initial begin
    #20000;
    miscompares++;
    end_of_test();
  end
endmodule // tb
`default_nettype wire
